// ---- design/ppoc_pkg.sv ----
package ppoc_pkg;

   // ==========================================================
   // widths
   // ==========================================================
   localparam int ADDR_W = 8;    // register address from the serial front end
   localparam int DATA_W = 8;    // register data width
   localparam int PIN_COUNT = 4; // number of port pins
   localparam int CFG_COUNT = 4; // number of configurations A to D
   localparam int SRC_W = 3;     // width of a pin source field
   localparam int PAGE_W = 2;    // width of the page field
   localparam int FRAC_W = 21;   // fractional divider width
   localparam int FRAC_HI_W = 5; // fractional bits held in the upper register

   // ==========================================================
   // register offsets
   // ==========================================================
   localparam logic [ADDR_W-1:0] OFS_CH2_FRAC_LOWER = 8'h5E;
   localparam logic [ADDR_W-1:0] OFS_CH2_FRAC_MIDDLE = 8'h5F;
   localparam logic [ADDR_W-1:0] OFS_CH2_FRAC_UPPER = 8'h60;
   localparam logic [ADDR_W-1:0] OFS_CH3_FRAC_LOWER = 8'h62;
   localparam logic [ADDR_W-1:0] OFS_CH3_FRAC_MIDDLE = 8'h63;
   localparam logic [ADDR_W-1:0] OFS_CH3_FRAC_UPPER = 8'h64;
   localparam logic [ADDR_W-1:0] OFS_GLOBAL_BASE = 8'h80;  // first page-independent offset
   localparam logic [ADDR_W-1:0] OFS_PAGE_SELECT = 8'h80;
   localparam logic [ADDR_W-1:0] OFS_PINS01_SOURCE = 8'h81;
   localparam logic [ADDR_W-1:0] OFS_PINS23_SOURCE = 8'h82;
   localparam logic [ADDR_W-1:0] OFS_DRIVE_INV = 8'h83;
   localparam logic [ADDR_W-1:0] OFS_RX_LEVEL01 = 8'h84;

   // ==========================================================
   // reset values and writable masks
   // ==========================================================
   localparam logic [DATA_W-1:0] RST_FRAC_LOWER = 8'hF3;
   localparam logic [DATA_W-1:0] RST_FRAC_MIDDLE = 8'h07;
   localparam logic [DATA_W-1:0] RST_FRAC_UPPER = 8'h09;
   localparam logic [PAGE_W-1:0] RST_PAGE = 2'h0;
   localparam logic [DATA_W-1:0] RST_PINS01 = 8'h50;
   localparam logic [DATA_W-1:0] RST_PINS23 = 8'h12;
   localparam logic [DATA_W-1:0] RST_DRIVE_INV = 8'h00;
   localparam logic [DATA_W-1:0] RST_RX_LEVEL01 = 8'hFF;
   localparam logic [DATA_W-1:0] MASK_PINS = 8'h77;       // bits 7 and 3 read zero
   localparam logic [DATA_W-1:0] MASK_FRAC_UPPER = 8'h3F; // bits 7:6 read zero
   localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;

   // ==========================================================
   // field positions
   // ==========================================================
   localparam int PAGE_LSB = 0;
   localparam int SRC_LO_LSB = 0;   // pin 0 / pin 2 source
   localparam int SRC_HI_LSB = 4;   // pin 1 / pin 3 source
   localparam int INV_LSB = 0;      // inversion bits 3:0
   localparam int HIGH_POWER_LSB = 4; // pad drive bits 7:4
   localparam int SPUR_BIT = 5;
   localparam int RX_PIN0_LSB = 0;  // pin 0 polarity, configs A..D at 0..3
   localparam int RX_PIN1_LSB = 4;  // pin 1 polarity, configs A..D at 4..7
   localparam logic [PAGE_W-1:0] PAGE_CFG_A = 2'h0;

   // ==========================================================
   // pin source encoding
   // ==========================================================
   localparam logic [SRC_W-1:0] SRC_CLOCK = 3'h0;
   localparam logic [SRC_W-1:0] SRC_RX_RUN = 3'h1;
   localparam logic [SRC_W-1:0] SRC_INTERRUPT = 3'h2;
   localparam logic [SRC_W-1:0] SRC_LOW = 3'h3;
   localparam logic [SRC_W-1:0] SRC_HIGH = 3'h4;
   localparam logic [SRC_W-1:0] SRC_SLICED = 3'h5;
   localparam logic [SRC_W-1:0] SRC_MATCHED = 3'h6;

   // ==========================================================
   // carriers
   // ==========================================================
   // one decoded register access from the serial front end
   typedef struct packed {
      logic write;
      logic read;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } ppoc_regreq_t;

   // internal signals that may be routed to a pin
   typedef struct packed {
      logic clkOut;
      logic rxRunning;       // active high, before polarity
      logic interruptLowActive;
      logic slicedData;
      logic matchedFilterData;
   } ppoc_sig_t;

   // state of one pin multiplexer
   typedef struct packed {
      logic pin;
   } ppoc_pin_state_t;

   // state of the register block
   typedef struct packed {
      logic [PAGE_W-1:0] page;
      logic [DATA_W-1:0] pins01;
      logic [DATA_W-1:0] pins23;
      logic [DATA_W-1:0] driveInv;
      logic [DATA_W-1:0] rxLevel01;
      logic [DATA_W-1:0] ch2Lower;
      logic [DATA_W-1:0] ch2Middle;
      logic [DATA_W-1:0] ch2Upper;
      logic [DATA_W-1:0] ch3Lower;
      logic [DATA_W-1:0] ch3Middle;
      logic [DATA_W-1:0] ch3Upper;
      logic [DATA_W-1:0] rdata;
   } ppoc_state_t;

endpackage

// ---- design/ppoc_pin_mux.sv ----
`timescale 1ns/1ps
module ppoc_pin_mux #(
   parameter bit CLOCK_OK = 1'b1 // pin may carry the clock output
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // configuration
   input wire logic [ppoc_pkg::SRC_W-1:0] src,
   input wire logic invert,
   // routable signals
   input wire ppoc_pkg::ppoc_sig_t sig,
   input wire logic rxLevel,
   // pin
   output logic pin
);
   import ppoc_pkg::*;

   // ==========================================================
   // state
   // ==========================================================
   ppoc_pin_state_t state_reg; // registered pin level
   ppoc_pin_state_t state_next; // next pin level
   logic selected; // source before inversion

   // source selection, then inversion
   always_comb begin
      selected = 1'b0;
      case (src)
         SRC_CLOCK: begin
            selected = CLOCK_OK ? sig.clkOut : 1'b0;
         end
         SRC_RX_RUN: begin
            selected = rxLevel;
         end
         SRC_INTERRUPT: begin
            selected = sig.interruptLowActive;
         end
         SRC_LOW: begin
            selected = 1'b0;
         end
         SRC_HIGH: begin
            selected = 1'b1;
         end
         SRC_SLICED: begin
            selected = sig.slicedData;
         end
         SRC_MATCHED: begin
            selected = sig.matchedFilterData;
         end
         default: begin
            // unused code drives a quiet low
            selected = 1'b0;
         end
      endcase
      state_next.pin = selected ^ invert;
   end

   // register the pin so it never glitches across a source change
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign pin = state_reg.pin;

endmodule // ppoc_pin_mux

// ---- design/ppoc_port_pins.sv ----
`timescale 1ns/1ps
module ppoc_port_pins (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // decoded register access
   input wire ppoc_pkg::ppoc_regreq_t regReq,
   output logic [ppoc_pkg::DATA_W-1:0] regRdata,
   // receiver signals
   input wire ppoc_pkg::ppoc_sig_t sig,
   input wire logic [ppoc_pkg::PAGE_W-1:0] activeConfig,
   // port pins and pad drive
   output logic [ppoc_pkg::PIN_COUNT-1:0] portPin,
   output logic [ppoc_pkg::PIN_COUNT-1:0] padHighPower,
   // configuration to other blocks
   output logic [ppoc_pkg::PAGE_W-1:0] configPage,
   output logic [ppoc_pkg::FRAC_W-1:0] ch2Frac,
   output logic [ppoc_pkg::FRAC_W-1:0] ch3Frac,
   output logic ch2SpurEnable,
   output logic ch3SpurEnable
);
   import ppoc_pkg::*;

   // ==========================================================
   // declarations
   // ==========================================================
   ppoc_state_t state_reg; // all register state
   ppoc_state_t state_next; // next register state
   logic pageOk; // access reaches this block's page
   logic [DATA_W-1:0] readValue; // value at the read address
   logic [PIN_COUNT-1:0][SRC_W-1:0] pinSrc; // per pin source code
   logic [PIN_COUNT-1:0] pinInv; // per pin inversion
   logic [PIN_COUNT-1:0] rxLevel; // receive-running after polarity
   logic [CFG_COUNT-1:0] pin0Pol; // pin 0 polarity per configuration
   logic [CFG_COUNT-1:0] pin1Pol; // pin 1 polarity per configuration

   // ==========================================================
   // address decode
   // ==========================================================
   // only page A of the paged range is held here; other pages belong
   // to configuration stores outside this block and read as zero
   always_comb begin
      if (regReq.addr < OFS_GLOBAL_BASE) begin
         pageOk = (state_reg.page == PAGE_CFG_A);
      end else begin
         pageOk = 1'b1;
      end
   end

   // read mux, unmapped offsets give zero
   always_comb begin
      readValue = READ_UNMAPPED;
      if (pageOk) begin
         case (regReq.addr)
            OFS_CH2_FRAC_LOWER: readValue = state_reg.ch2Lower;
            OFS_CH2_FRAC_MIDDLE: readValue = state_reg.ch2Middle;
            OFS_CH2_FRAC_UPPER: readValue = state_reg.ch2Upper;
            OFS_CH3_FRAC_LOWER: readValue = state_reg.ch3Lower;
            OFS_CH3_FRAC_MIDDLE: readValue = state_reg.ch3Middle;
            OFS_CH3_FRAC_UPPER: readValue = state_reg.ch3Upper;
            OFS_PAGE_SELECT: readValue = {{(DATA_W-PAGE_W){1'b0}}, state_reg.page};
            OFS_PINS01_SOURCE: readValue = state_reg.pins01;
            OFS_PINS23_SOURCE: readValue = state_reg.pins23;
            OFS_DRIVE_INV: readValue = state_reg.driveInv;
            OFS_RX_LEVEL01: readValue = state_reg.rxLevel01;
            default: readValue = READ_UNMAPPED;
         endcase
      end
   end

   // ==========================================================
   // register writes
   // ==========================================================
   // a write and a read in the same cycle: the read returns the old value
   always_comb begin
      state_next = state_reg;
      if (regReq.write && pageOk) begin
         case (regReq.addr)
            OFS_CH2_FRAC_LOWER: state_next.ch2Lower = regReq.wdata;
            OFS_CH2_FRAC_MIDDLE: state_next.ch2Middle = regReq.wdata;
            OFS_CH3_FRAC_LOWER: state_next.ch3Lower = regReq.wdata;
            OFS_CH3_FRAC_MIDDLE: state_next.ch3Middle = regReq.wdata;
            OFS_CH2_FRAC_UPPER: state_next.ch2Upper = regReq.wdata & MASK_FRAC_UPPER;
            OFS_CH3_FRAC_UPPER: state_next.ch3Upper = regReq.wdata & MASK_FRAC_UPPER;
            OFS_PAGE_SELECT: state_next.page = regReq.wdata[PAGE_LSB +: PAGE_W];
            OFS_PINS01_SOURCE: state_next.pins01 = regReq.wdata & MASK_PINS;
            OFS_PINS23_SOURCE: state_next.pins23 = regReq.wdata & MASK_PINS;
            OFS_DRIVE_INV: state_next.driveInv = regReq.wdata;
            OFS_RX_LEVEL01: state_next.rxLevel01 = regReq.wdata;
            default: begin
               // unmapped write is dropped
               state_next = state_reg;
            end
         endcase
      end
      if (regReq.read) begin
         state_next.rdata = readValue;
      end
   end

   // single register for all state, synchronous reset
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_reg.page <= RST_PAGE;
         state_reg.pins01 <= RST_PINS01;
         state_reg.pins23 <= RST_PINS23;
         state_reg.driveInv <= RST_DRIVE_INV;
         state_reg.rxLevel01 <= RST_RX_LEVEL01;
         state_reg.ch2Lower <= RST_FRAC_LOWER;
         state_reg.ch2Middle <= RST_FRAC_MIDDLE;
         state_reg.ch2Upper <= RST_FRAC_UPPER;
         state_reg.ch3Lower <= RST_FRAC_LOWER;
         state_reg.ch3Middle <= RST_FRAC_MIDDLE;
         state_reg.ch3Upper <= RST_FRAC_UPPER;
         state_reg.rdata <= READ_UNMAPPED;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================================
   // configuration outputs
   // ==========================================================
   assign regRdata = state_reg.rdata;
   assign configPage = state_reg.page;
   assign padHighPower = state_reg.driveInv[HIGH_POWER_LSB +: PIN_COUNT];
   assign ch2Frac = {state_reg.ch2Upper[FRAC_HI_W-1:0], state_reg.ch2Middle,
      state_reg.ch2Lower};
   assign ch3Frac = {state_reg.ch3Upper[FRAC_HI_W-1:0], state_reg.ch3Middle,
      state_reg.ch3Lower};
   assign ch2SpurEnable = state_reg.ch2Upper[SPUR_BIT];
   assign ch3SpurEnable = state_reg.ch3Upper[SPUR_BIT];

   // ==========================================================
   // pin routing
   // ==========================================================
   assign pinSrc[0] = state_reg.pins01[SRC_LO_LSB +: SRC_W];
   assign pinSrc[1] = state_reg.pins01[SRC_HI_LSB +: SRC_W];
   assign pinSrc[2] = state_reg.pins23[SRC_LO_LSB +: SRC_W];
   assign pinSrc[3] = state_reg.pins23[SRC_HI_LSB +: SRC_W];
   assign pinInv = state_reg.driveInv[INV_LSB +: PIN_COUNT];
   assign pin0Pol = state_reg.rxLevel01[RX_PIN0_LSB +: CFG_COUNT];
   assign pin1Pol = state_reg.rxLevel01[RX_PIN1_LSB +: CFG_COUNT];

   // receive-running level per pin for the running configuration;
   // pins 2 and 3 have their polarity bits elsewhere, so they stay high-active
   always_comb begin
      rxLevel[0] = pin0Pol[activeConfig] ? sig.rxRunning : ~sig.rxRunning;
      rxLevel[1] = pin1Pol[activeConfig] ? sig.rxRunning : ~sig.rxRunning;
      rxLevel[2] = sig.rxRunning;
      rxLevel[3] = sig.rxRunning;
   end

   // one multiplexer per pin; pin 3 refuses the clock source
   for (genvar i = 0; i < PIN_COUNT; i++) begin : gPin
      ppoc_pin_mux #(
         .CLOCK_OK(i != 3)
      ) uMux (
         .clk(clk),
         .rst_b(rst_b),
         .src(pinSrc[i]),
         .invert(pinInv[i]),
         .sig(sig),
         .rxLevel(rxLevel[i]),
         .pin(portPin[i])
      );
   end

   // ==========================================================
   // checks
   // ==========================================================
   chk_page_write: assert property (
      @(posedge clk) disable iff (!rst_b)
      regReq.write && regReq.addr == OFS_PAGE_SELECT
      |=> configPage == $past(regReq.wdata[1:0]))
      else $error("page field did not take the written value");

   chk_page_gate: assert property (
      @(posedge clk) disable iff (!rst_b)
      regReq.write && regReq.addr == OFS_CH3_FRAC_LOWER && configPage != PAGE_CFG_A
      |=> $stable(ch3Frac))
      else $error("paged write landed while another page was selected");

   chk_pin0_clock: assert property (
      @(posedge clk) disable iff (!rst_b)
      pinSrc[0] == SRC_CLOCK && !pinInv[0]
      |=> portPin[0] == $past(sig.clkOut))
      else $error("pin 0 does not follow clock output");

   chk_pin1_sliced: assert property (
      @(posedge clk) disable iff (!rst_b)
      pinSrc[1] == SRC_SLICED && !pinInv[1]
      |=> portPin[1] == $past(sig.slicedData))
      else $error("pin 1 does not follow sliced data");

   chk_pin2_interrupt: assert property (
      @(posedge clk) disable iff (!rst_b)
      pinSrc[2] == SRC_INTERRUPT && !pinInv[2]
      |=> portPin[2] == $past(sig.interruptLowActive))
      else $error("pin 2 does not follow interrupt");

   chk_pin3_noclock: assert property (
      @(posedge clk) disable iff (!rst_b)
      pinSrc[3] == SRC_CLOCK
      |=> portPin[3] == $past(pinInv[3]))
      else $error("pin 3 carried something on the unused clock code");

   chk_invert_const: assert property (
      @(posedge clk) disable iff (!rst_b)
      pinSrc[0] == SRC_HIGH && pinInv[0]
      |=> !portPin[0])
      else $error("inverted constant high did not drive low");

   chk_invert_data: assert property (
      @(posedge clk) disable iff (!rst_b)
      pinSrc[1] == SRC_MATCHED && pinInv[1]
      |=> portPin[1] != $past(sig.matchedFilterData))
      else $error("inversion bit did not invert pin 1");

   chk_frac_lower: assert property (
      @(posedge clk) disable iff (!rst_b)
      regReq.write && regReq.addr == OFS_CH3_FRAC_LOWER && configPage == PAGE_CFG_A
      |=> ch3Frac[7:0] == $past(regReq.wdata) ##1 ($stable(ch3Frac) || $past(regReq.write)))
      else $error("fractional low byte not stored");

   chk_spur_enable: assert property (
      @(posedge clk) disable iff (!rst_b)
      regReq.write && regReq.addr == OFS_CH2_FRAC_UPPER && configPage == PAGE_CFG_A
      |=> ch2SpurEnable == $past(regReq.wdata[5]) && ch2Frac[20:16] == $past(regReq.wdata[4:0]))
      else $error("upper fractional register not stored");

   chk_rx_level: assert property (
      @(posedge clk) disable iff (!rst_b)
      pinSrc[0] == SRC_RX_RUN && !pinInv[0] && sig.rxRunning
      |=> portPin[0] == $past(pin0Pol[activeConfig]))
      else $error("pin 0 receive-running level ignores polarity");

   chk_read_back: assert property (
      @(posedge clk) disable iff (!rst_b)
      regReq.read && regReq.addr == OFS_RX_LEVEL01
      |=> regRdata == $past(state_reg.rxLevel01))
      else $error("polarity register read back wrong");

   chk_page_hold: assert property (
      @(posedge clk) disable iff (!rst_b)
      !(regReq.write && regReq.addr == OFS_PAGE_SELECT)
      |=> $stable(configPage))
      else $error("page field moved without a page write");

   chk_refused_read: assert property (
      @(posedge clk) disable iff (!rst_b)
      regReq.read && regReq.addr < OFS_GLOBAL_BASE && configPage != PAGE_CFG_A
      |=> regRdata == READ_UNMAPPED)
      else $error("paged read returned data while another page was selected");

   chk_unused_code: assert property (
      @(posedge clk) disable iff (!rst_b)
      &pinSrc[0]
      |=> portPin[0] == $past(pinInv[0]))
      else $error("pin 0 carried something on the unused code");

   chk_src_write: assert property (
      @(posedge clk) disable iff (!rst_b)
      regReq.write && regReq.addr == OFS_PINS01_SOURCE
      |=> pinSrc[1] == $past(regReq.wdata[6:4]) && pinSrc[0] == $past(regReq.wdata[2:0]))
      else $error("pin 0/1 source fields not stored");

   chk_pin2_rxrun: assert property (
      @(posedge clk) disable iff (!rst_b)
      pinSrc[2] == SRC_RX_RUN && !pinInv[2]
      |=> portPin[2] == $past(sig.rxRunning))
      else $error("pin 2 does not follow receive-running");

   chk_pin3_matched: assert property (
      @(posedge clk) disable iff (!rst_b)
      pinSrc[3] == SRC_MATCHED && !pinInv[3]
      |=> portPin[3] == $past(sig.matchedFilterData))
      else $error("pin 3 does not follow matched filter data");

   chk_inv_write: assert property (
      @(posedge clk) disable iff (!rst_b)
      regReq.write && regReq.addr == OFS_DRIVE_INV
      |=> pinInv == $past(regReq.wdata[3:0]) && padHighPower == $past(regReq.wdata[7:4]))
      else $error("inversion and drive bits not stored");

   chk_ch3_spur: assert property (
      @(posedge clk) disable iff (!rst_b)
      regReq.write && regReq.addr == OFS_CH3_FRAC_UPPER && configPage == PAGE_CFG_A
      |=> ch3SpurEnable == $past(regReq.wdata[5]) && ch3Frac[20:16] == $past(regReq.wdata[4:0]))
      else $error("channel 3 upper fractional register not stored");

   chk_rx_level_low: assert property (
      @(posedge clk) disable iff (!rst_b)
      pinSrc[1] == SRC_RX_RUN && !pinInv[1] && !sig.rxRunning
      |=> portPin[1] == !$past(pin1Pol[activeConfig]))
      else $error("pin 1 idle receive-running level ignores polarity");

endmodule // ppoc_port_pins

// ---- bench/ppoc_host_model.sv ----
`timescale 1ns/1ps
module ppoc_host_model (
   // clock
   input wire logic clk,
   // register requests toward the device and its answer
   output ppoc_pkg::ppoc_regreq_t regReq,
   input wire logic [ppoc_pkg::DATA_W-1:0] regRdata
);
   import ppoc_pkg::*;

   // ==========================================================
   // access tasks
   // ==========================================================
   // bus idle from time zero so nothing is taken during reset
   initial begin
      regReq = '0;
   end

   // one write, the strobe stands for exactly one taking edge
   task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      regReq <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      // released qualifiers show garbage, not the old value
      regReq <= '{write: 1'b0, read: 1'b0, addr: ~a, wdata: ~d};
   endtask

   // one read, data is taken once the answering edge has landed
   task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clk);
      regReq <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      regReq <= '{write: 1'b0, read: 1'b0, addr: ~a, wdata: 8'hA5};
      #1;
      d = regRdata;
   endtask

   task automatic set_page(input logic [PAGE_W-1:0] pg);
      write_reg(OFS_PAGE_SELECT, {6'h00, pg});
   endtask

   // fractional byte split
   // the host owns the ratio math, here it only splits the 21-bit field
   task automatic write_frac(input logic [ADDR_W-1:0] base, input logic [FRAC_W-1:0] f,
      input logic spur);
      write_reg(base, f[7:0]);
      write_reg(base + 8'h01, f[15:8]);
      write_reg(base + 8'h02, {2'b00, spur, f[20:16]});
   endtask
endmodule // ppoc_host_model

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
   import ppoc_pkg::*;

   // ==========================================================
   // signals
   // ==========================================================
   logic clk = 1'b0;
   logic rst_b = 1'b0; // synchronous, active low
   ppoc_regreq_t regReq;
   logic [DATA_W-1:0] regRdata;
   ppoc_sig_t sig = '0;
   logic [PAGE_W-1:0] activeConfig = '0;
   logic [PIN_COUNT-1:0] portPin;
   logic [PIN_COUNT-1:0] padHighPower;
   logic [PAGE_W-1:0] configPage;
   logic [FRAC_W-1:0] ch2Frac;
   logic [FRAC_W-1:0] ch3Frac;
   logic ch2SpurEnable;
   logic ch3SpurEnable;
   int failCount = 0;
   int comparisons = 0;
   // reset readback table
   logic [7:0] rstAddr [11] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h5E, 8'h5F, 8'h60,
      8'h62, 8'h63, 8'h64};
   logic [7:0] rstVal [11] = '{8'h00, 8'h50, 8'h12, 8'h00, 8'hFF, 8'hF3, 8'h07, 8'h09,
      8'hF3, 8'h07, 8'h09};

   // 40 MHz clock
   always #12.5 clk = ~clk;

   ppoc_port_pins dut (.clk(clk), .rst_b(rst_b), .regReq(regReq), .regRdata(regRdata),
      .sig(sig), .activeConfig(activeConfig), .portPin(portPin),
      .padHighPower(padHighPower), .configPage(configPage), .ch2Frac(ch2Frac),
      .ch3Frac(ch3Frac), .ch2SpurEnable(ch2SpurEnable), .ch3SpurEnable(ch3SpurEnable));

   ppoc_host_model hostModel (.clk(clk), .regReq(regReq), .regRdata(regRdata));

   // ==========================================================
   // checking helpers
   // ==========================================================
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failCount++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   // expected pin level: source pick, polarity, then inversion last
   function automatic logic pin_expect(input int p, input logic [2:0] code, input logic inv,
      input ppoc_sig_t s, input logic [7:0] lvl, input logic [1:0] cfg);
      logic v;
      case (code)
         3'h0: v = (p == 3) ? 1'b0 : s.clkOut; // pin 3 has no clock output
         3'h1: v = (p > 1) ? s.rxRunning : (s.rxRunning ^ ~lvl[p * 4 + cfg]);
         3'h2: v = s.interruptLowActive;
         3'h3: v = 1'b0;
         3'h4: v = 1'b1;
         3'h5: v = s.slicedData;
         3'h6: v = s.matchedFilterData;
         default: v = 1'b0; // unused code drives low
      endcase
      return v ^ inv;
   endfunction

   task automatic reportAndStop();
      $display("comparisons=%0d mismatches=%0d", comparisons, failCount);
      if (failCount == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ==========================================================
   // main sequence
   // ==========================================================
   initial begin
      logic [7:0] d;
      logic [7:0] inv;
      logic [7:0] lvl;
      logic [2:0] code;
      logic [FRAC_W-1:0] f;
      logic sp;
      logic [7:0] ch3Low;
      logic pinExp; // expected level of the pin under check
      void'($urandom(37));
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      #1;
      check(ch2Frac, 21'h09_07F3);
      check(ch3Frac, 21'h09_07F3);
      check({ch2SpurEnable, ch3SpurEnable, configPage}, 4'h0);
      for (int i = 0; i < 11; i++) begin
         hostModel.read_reg(rstAddr[i], d);
         check(d, rstVal[i]);
      end
      // unused bits read zero, unmapped offset reads zero
      hostModel.write_reg(OFS_PINS01_SOURCE, 8'hFF);
      hostModel.read_reg(OFS_PINS01_SOURCE, d);
      check(d, 8'h77);
      hostModel.write_reg(OFS_CH2_FRAC_UPPER, 8'hFF);
      hostModel.read_reg(OFS_CH2_FRAC_UPPER, d);
      check(d, 8'h3F);
      check({ch2SpurEnable, ch2Frac[20:16]}, 6'h3F);
      hostModel.read_reg(8'h90, d);
      check(d, 8'h00);
      // fractional values: all zero, all ones, then random
      for (int k = 0; k < 4; k++) begin
         f = (k == 0) ? 21'h00_0000 : (k == 1) ? 21'h1F_FFFF : 21'($urandom);
         sp = k[0];
         hostModel.write_frac(OFS_CH2_FRAC_LOWER, f, sp);
         hostModel.write_frac(OFS_CH3_FRAC_LOWER, ~f, ~sp);
         #1;
         check(ch2Frac, f);
         check(ch3Frac, 21'(~f));
         check({ch2SpurEnable, ch3SpurEnable}, {sp, ~sp});
      end
      ch3Low = ~f[7:0];
      // other pages hide the paged offsets
      for (int pg = 1; pg < 4; pg++) begin
         hostModel.set_page(2'(pg));
         #1;
         check(configPage, pg);
         hostModel.write_reg(OFS_CH3_FRAC_LOWER, 8'h5A);
         hostModel.read_reg(OFS_CH3_FRAC_LOWER, d);
         check(d, 8'h00);
      end
      hostModel.set_page(2'h0);
      hostModel.read_reg(OFS_CH3_FRAC_LOWER, d);
      check(d, ch3Low);
      // every source code on every pin, random polarity; three passes over the codes:
      // random inversion, none, then all pins inverted so every case is reached
      for (int c = 0; c < 24; c++) begin
         code = 3'(c);
         inv = 8'($urandom);
         if (c >= 8) begin
            inv[3:0] = (c >= 16) ? 4'hF : 4'h0;
         end
         lvl = 8'($urandom);
         hostModel.write_reg(OFS_PINS01_SOURCE, {1'b0, code, 1'b0, code});
         hostModel.write_reg(OFS_PINS23_SOURCE, {1'b0, code, 1'b0, code});
         hostModel.write_reg(OFS_DRIVE_INV, inv);
         hostModel.write_reg(OFS_RX_LEVEL01, lvl);
         #1;
         check(padHighPower, inv[7:4]);
         repeat (8) begin
            @(posedge clk);
            sig <= 5'($urandom);
            activeConfig <= 2'($urandom);
            @(posedge clk);
            #1;
            for (int p = 0; p < 4; p++) begin
               pinExp = pin_expect(p, code, inv[p], sig, lvl, activeConfig);
               check(portPin[p], pinExp);
            end
         end
      end
      reportAndStop();
   end
endmodule // testbench
